// ==== ctb_chk.sv ====
// Port assertions for the character test branch unit
`timescale 1ns/1ps
`default_nettype none
module ctb_chk #(
  parameter int unsigned ADDR_W = 18
) (
  input wire logic                 CLOCK,
  input wire logic                 RST_B,
  input wire logic                 COMPARE_MODE,
  input wire logic                 INSTR_VALID,
  input wire ctb_pkg::ctb_instr_t  INSTR,
  input wire logic                 MEM_ACK,
  input wire logic                 BUSY,
  input wire logic                 MEM_REQ,
  input wire logic [ADDR_W-1:0]    MEM_ADDR,
  input wire ctb_pkg::ctb_result_t RESULT,
  input wire logic [1:0]           COMPARE_IND,
  input wire logic [5:0]           VARIANT_HELD
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  a_issue_starts_fetch: assert property (INSTR_VALID && !BUSY |=> BUSY ##1 MEM_REQ)
    else $error("fetch not started after issue");
  a_fetch_at_b: assert property (INSTR_VALID && !BUSY && !INSTR.fmt[1] |=> ##1 MEM_ADDR == $past(INSTR.b_addr, 2))
    else $error("fetch address is not the B address");
  a_ack_then_done: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ ##1 (RESULT.done && !BUSY))
    else $error("result not two cycles after data");
  a_done_single: assert property (RESULT.done |=> !RESULT.done)
    else $error("done longer than one cycle");
  a_fall_bar: assert property (RESULT.done && !RESULT.taken |-> RESULT.bar == $past(MEM_ADDR, 2) - 1'b1)
    else $error("fall through B register wrong");
  a_taken_target: assert property (RESULT.done && RESULT.taken |-> RESULT.next_seq == RESULT.first_operand_address_register)
    else $error("branch target differs from A register");
  a_var_kept: assert property (INSTR_VALID && !BUSY && INSTR.fmt != ctb_pkg::FMT_A |=> $stable(VARIANT_HELD) [*4])
    else $error("held variant changed");
  a_ind_quiet: assert property (!COMPARE_MODE |=> $stable(COMPARE_IND))
    else $error("indicators changed outside compare mode");
endmodule
bind ctb_unit ctb_chk #(.ADDR_W(ADDR_W)) u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .COMPARE_MODE(COMPARE_MODE),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .MEM_ACK(MEM_ACK), .BUSY(BUSY), .MEM_REQ(MEM_REQ),
  .MEM_ADDR(MEM_ADDR), .RESULT(RESULT), .COMPARE_IND(COMPARE_IND), .VARIANT_HELD(VARIANT_HELD));
`default_nettype wire

// ==== ctb_cond.sv ====
// Condition evaluator for the character condition branch
`timescale 1ns/1ps
`default_nettype none
module ctb_cond (
  input  wire logic                       legacy,
  input  wire logic [ctb_pkg::CHAR_W-1:0] variant,
  input  wire ctb_pkg::ctb_char_t         ch,
  output logic                            hit
);
  logic [2:0] hi;
  logic [2:0] lo;
  logic       zone_ok;
  logic       punc_ok;

  always_comb begin
    hi = variant[5:3];
    lo = variant[2:0];
    if (legacy && hi == ctb_pkg::DIG_SPEC) begin
      hi = 3'h3;
    end
    case (lo)
      3'h0:    zone_ok = 1'b1;
      3'h1:    zone_ok = ch.zone_a;
      3'h2:    zone_ok = ch.zone_b;
      3'h3:    zone_ok = ch.zone_b & ch.zone_a;
      3'h4:    zone_ok = ~ch.zone_b & ~ch.zone_a;
      3'h5:    zone_ok = ~ch.zone_b & ch.zone_a;
      3'h6:    zone_ok = ch.zone_b & ~ch.zone_a;
      3'h7:    zone_ok = ch.zone_b & ch.zone_a;
      default: zone_ok = 1'b0;
    endcase
    case (hi)
      3'h0:    punc_ok = 1'b1;
      3'h1:    punc_ok = ch.word_mark;
      3'h2:    punc_ok = ch.item_mark;
      3'h3:    punc_ok = ch.word_mark & ch.item_mark;
      3'h4:    punc_ok = ~ch.word_mark & ~ch.item_mark;
      3'h5:    punc_ok = ch.word_mark & ~ch.item_mark;
      3'h6:    punc_ok = ~ch.word_mark & ch.item_mark;
      default: punc_ok = 1'b0;
    endcase
    if (hi == ctb_pkg::DIG_SPEC) begin
      // Standard special group: OR with word mark, X0 unconditional
      hit = (lo == ctb_pkg::DIG_NONE) | zone_ok | ch.word_mark;
    end else begin
      // A zero digit yields true, so AND covers all three cases
      hit = zone_ok & punc_ok;
    end
  end
endmodule
`default_nettype wire

// ==== ctb_mem.sv ====
// Read-only memory model: character is the low address byte
`timescale 1ns/1ps
`default_nettype none
module ctb_mem (
  input  wire logic                        clock,
  input  wire logic                        mem_req,
  input  wire logic [ctb_pkg::ADDR_W-1:0]  mem_addr,
  output logic                             mem_ack,
  output ctb_pkg::ctb_char_t               mem_rdata
);
  logic [1:0] wait_r = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = '0;
  // Never writes, so punctuation in memory stays as it was
  always @(posedge clock) begin
    mem_rdata <= ~mem_rdata; // Idle data toggles so stale values never pass
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack) begin
      if (wait_r == mem_addr[9:8]) begin
        mem_ack <= 1'b1;
        mem_rdata <= ctb_pkg::ctb_char_t'(mem_addr[7:0]);
        wait_r <= 2'h0;
      end else wait_r <= wait_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== ctb_pkg.sv ====
// Package for the character test branch unit
package ctb_pkg;
  localparam int unsigned ADDR_W    = 18;
  localparam int unsigned CHAR_W    = 6;
  localparam logic [2:0]  DIG_NONE  = 3'h0;
  localparam logic [2:0]  DIG_SPEC  = 3'h7;
  localparam logic [5:0]  VAR_RST   = 6'h00;
  localparam logic [1:0]  CMP_EQ    = 2'h0;
  localparam logic [1:0]  CMP_LOW   = 2'h1;
  localparam logic [1:0]  CMP_HIGH  = 2'h2;
  localparam logic [1:0]  CMP_RST   = 2'h0;
  localparam logic [1:0]  FMT_A     = 2'h0;
  localparam logic [1:0]  FMT_B     = 2'h1;
  localparam logic [1:0]  FMT_C     = 2'h2;
  localparam logic [1:0]  FMT_D     = 2'h3;
  localparam logic [1:0]  OP_COND   = 2'h0;
  localparam logic [1:0]  OP_EQUAL  = 2'h1;

  typedef enum logic [1:0] {
    CTB_IDLE  = 2'b00,
    CTB_FETCH = 2'b01,
    CTB_WAIT  = 2'b10,
    CTB_EXEC  = 2'b11
  } ctb_state_t;

  // Memory character: data bits plus punctuation bits
  typedef struct packed {
    logic              word_mark;
    logic              item_mark;
    logic              zone_b;
    logic              zone_a;
    logic [3:0]        numeric;
  } ctb_char_t;

  // One issued instruction
  typedef struct packed {
    logic [1:0]        op;
    logic [1:0]        fmt;
    logic [ADDR_W-1:0] a_addr;
    logic [ADDR_W-1:0] b_addr;
    logic [CHAR_W-1:0] variant;
  } ctb_instr_t;

  // Outcome of one instruction
  typedef struct packed {
    logic              done;
    logic              taken;
    logic [ADDR_W-1:0] next_seq;
    logic [ADDR_W-1:0] first_operand_address_register;
    logic [ADDR_W-1:0] bar;
  } ctb_result_t;
endpackage

// ==== ctb_unit.sv ====
// Character test branch unit: condition and equality branches
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - low octal digit selects zone-bit test
// - high octal digit selects punctuation test
// - zero digit ignored, else both conditions
// - standard 70 branches unconditionally
// - standard 7X: zone test or word mark
// - legacy mode treats 7X as 3X
// - basic condition set always supported
// - taken branch jumps, sequence saved to B
// - fall through: B is B-1, A kept
// - A address loaded, taken uses full register
// - formats b, c, d reuse stored variant
// - formats c, d fetch at B register
// - format d target from A register
// - equality branch on exact bit match
// - word mark ignored, never written
// - compare mode sets comparison indicators on equality branches only
module ctb_unit #(
  parameter int unsigned ADDR_W = ctb_pkg::ADDR_W
) (
  input  wire logic                       CLOCK,
  input  wire logic                       RST_B,
  input  wire logic                       LEGACY_MODE,
  input  wire logic                       COMPARE_MODE,
  input  wire logic                       INSTR_VALID,
  input  wire ctb_pkg::ctb_instr_t        INSTR,
  input  wire logic [ADDR_W-1:0]          SEQ_IN,
  input  wire logic                       MEM_ACK,
  input  wire ctb_pkg::ctb_char_t         MEM_RDATA,
  output logic                            BUSY,
  output logic                            MEM_REQ,
  output logic [ADDR_W-1:0]               MEM_ADDR,
  output ctb_pkg::ctb_result_t            RESULT,
  output logic [1:0]                      COMPARE_IND,
  output logic [ctb_pkg::CHAR_W-1:0]      VARIANT_HELD
);
  typedef struct packed {
    ctb_pkg::ctb_state_t          st;
    logic [1:0]                   op;
    logic [1:0]                   fmt;
    logic [ADDR_W-1:0]            first_operand_address_register;
    logic [ADDR_W-1:0]            bar;
    logic [ADDR_W-1:0]            seq;
    logic [ctb_pkg::CHAR_W-1:0]   var_held;
    ctb_pkg::ctb_char_t           ch;
    logic                         mem_req;
    ctb_pkg::ctb_result_t         res;
    logic [1:0]                   cmp;
    logic                         busy;
  } ctb_regs_t;

  ctb_regs_t s_r;
  ctb_regs_t s_nxt;
  logic      cond_hit;
  logic      eq_hit;
  logic      taken;
  logic [5:0] ch_data;

  // Only the data bits take part in the equality test
  assign ch_data = {s_r.ch.zone_b, s_r.ch.zone_a, s_r.ch.numeric};

  ctb_cond u_cond (
    .legacy  (LEGACY_MODE),
    .variant (s_r.var_held),
    .ch      (s_r.ch),
    .hit     (cond_hit)
  );

  assign eq_hit = (ch_data == s_r.var_held);
  assign taken  = (s_r.op == ctb_pkg::OP_EQUAL) ? eq_hit : cond_hit;

  always_comb begin
    s_nxt = s_r;
    s_nxt.res.done = 1'b0;
    case (s_r.st)
      ctb_pkg::CTB_IDLE: begin
        if (INSTR_VALID) begin
          s_nxt.op  = INSTR.op;
          s_nxt.fmt = INSTR.fmt;
          s_nxt.seq = SEQ_IN;
          if (INSTR.fmt == ctb_pkg::FMT_A) begin
            s_nxt.var_held = INSTR.variant;
          end
          if (INSTR.fmt != ctb_pkg::FMT_D) begin
            // Whole field supplied here; narrower addresses would merge upper bits upstream
            s_nxt.first_operand_address_register = INSTR.a_addr;
          end
          if (INSTR.fmt == ctb_pkg::FMT_A || INSTR.fmt == ctb_pkg::FMT_B) begin
            s_nxt.bar = INSTR.b_addr;
          end
          s_nxt.st = ctb_pkg::CTB_FETCH;
        end
      end
      ctb_pkg::CTB_FETCH: begin
        s_nxt.mem_req = 1'b1;
        s_nxt.st      = ctb_pkg::CTB_WAIT;
      end
      ctb_pkg::CTB_WAIT: begin
        if (MEM_ACK) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.ch      = MEM_RDATA; // read only; memory is never written
          s_nxt.st      = ctb_pkg::CTB_EXEC;
        end
      end
      ctb_pkg::CTB_EXEC: begin
        s_nxt.res.done  = 1'b1;
        s_nxt.res.taken = taken;
        s_nxt.res.first_operand_address_register   = s_r.first_operand_address_register;
        if (taken) begin
          s_nxt.res.next_seq = s_r.first_operand_address_register;
          s_nxt.res.bar      = s_r.seq;
          s_nxt.bar          = s_r.seq;
        end else begin
          s_nxt.res.next_seq = s_r.seq;
          s_nxt.res.bar      = s_r.bar - {{(ADDR_W-1){1'b0}}, 1'b1};
          s_nxt.bar          = s_r.bar - {{(ADDR_W-1){1'b0}}, 1'b1};
        end
        if (s_r.op == ctb_pkg::OP_EQUAL && COMPARE_MODE) begin
          if (eq_hit) begin
            s_nxt.cmp = ctb_pkg::CMP_EQ;
          end else if (ch_data > s_r.var_held) begin
            s_nxt.cmp = ctb_pkg::CMP_HIGH;
          end else begin
            s_nxt.cmp = ctb_pkg::CMP_LOW;
          end
        end
        s_nxt.st = ctb_pkg::CTB_IDLE;
      end
      default: s_nxt.st = ctb_pkg::CTB_IDLE;
    endcase
    // Busy kept as its own flop so the port never decodes state combinationally
    s_nxt.busy = (s_nxt.st != ctb_pkg::CTB_IDLE);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s_r          <= '0;
      s_r.st       <= ctb_pkg::CTB_IDLE;
      s_r.var_held <= ctb_pkg::VAR_RST;
      s_r.cmp      <= ctb_pkg::CMP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    BUSY         = s_r.busy;
    MEM_REQ      = s_r.mem_req;
    MEM_ADDR     = s_r.bar;
    RESULT       = s_r.res;
    COMPARE_IND  = s_r.cmp;
    VARIANT_HELD = s_r.var_held;
  end
endmodule
`default_nettype wire

// ==== test_char_test_branch_unit.sv ====
// Self-checking testbench for the character test branch unit
`timescale 1ns/1ps
`default_nettype none
module test_char_test_branch_unit;
  localparam int AW = ctb_pkg::ADDR_W;
  logic                 clock = 1'b0, rst_b = 1'b0, lgm = 1'b0, cmm = 1'b0, iv = 1'b0, ack, busy, req;
  ctb_pkg::ctb_instr_t  ins = '0;
  ctb_pkg::ctb_char_t   rd;
  ctb_pkg::ctb_result_t res;
  logic [AW-1:0]        seq = '0, maddr, ar = '0, br = '0;
  logic [1:0]           ci, ec = ctb_pkg::CMP_RST;
  logic [5:0]           vh, ev = ctb_pkg::VAR_RST;
  logic [31:0]          rn = 32'hA1D85DE0;
  int                   fails = 0, checked = 0;
  ctb_unit DUT (.CLOCK(clock), .RST_B(rst_b), .LEGACY_MODE(lgm), .COMPARE_MODE(cmm), .INSTR_VALID(iv),
    .INSTR(ins), .SEQ_IN(seq), .MEM_ACK(ack), .MEM_RDATA(rd), .BUSY(busy), .MEM_REQ(req),
    .MEM_ADDR(maddr), .RESULT(res), .COMPARE_IND(ci), .VARIANT_HELD(vh));
  ctb_mem u_mem (.clock(clock), .mem_req(req), .mem_addr(maddr), .mem_ack(ack), .mem_rdata(rd));
  initial forever #2.5 clock = ~clock;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic cond(input logic lg, input logic [5:0] v, input logic [7:0] c);
    logic [2:0] h;
    logic       z, p;
    h = (lg && v[5:3] == 3'h7) ? 3'h3 : v[5:3];
    case (v[2:0])
      3'h0: z = 1'b1;
      3'h1: z = c[4];
      3'h2: z = c[5];
      3'h4: z = !c[5] && !c[4];
      3'h5: z = !c[5] && c[4];
      3'h6: z = c[5] && !c[4];
      default: z = c[5] && c[4];
    endcase
    p = (h == 3'h0) || (h == 3'h1 && c[7]) || (h == 3'h2 && c[6]) || (h == 3'h3 && c[7] && c[6])
      || (h == 3'h4 && !c[7] && !c[6]) || (h == 3'h5 && c[7] && !c[6]) || (h == 3'h6 && c[6] && !c[7]);
    if (h == 3'h7) return v[2:0] == 3'h0 || z || c[7];
    return z && p;
  endfunction
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(input logic [1:0] op, input logic [1:0] fm, input logic [AW-1:0] a, input logic [AW-1:0] b,
                     input logic [AW-1:0] s, input logic [5:0] v);
    logic [AW-1:0] eb;
    logic          hit;
    int            n;
    if (fm == ctb_pkg::FMT_A) ev = v;
    eb = fm[1] ? br : b;
    if (fm != ctb_pkg::FMT_D) ar = a;
    hit = (op == ctb_pkg::OP_EQUAL) ? (eb[5:0] == ev) : cond(lgm, ev, eb[7:0]);
    if (op == ctb_pkg::OP_EQUAL && cmm) ec = (eb[5:0] == ev) ? ctb_pkg::CMP_EQ :
      (eb[5:0] < ev) ? ctb_pkg::CMP_LOW : ctb_pkg::CMP_HIGH;
    @(posedge clock); #1;
    iv = 1'b1; ins = '{op, fm, a, b, v}; seq = s;
    @(posedge clock); #1;
    iv = 1'b0;
    n = 0;
    while (res.done !== 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
    chk({res.done, res.taken, res.next_seq, res.first_operand_address_register, res.bar},
        hit ? {2'h3, ar, ar, s} : {2'h2, s, ar, eb - 1'b1});
    chk(56'({ci, vh}), 56'({ec, ev}));
    br = hit ? s : eb - 1'b1;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 256; i++) begin
      rn = nx(rn);
      lgm = i[6]; cmm = i[7];
      run({1'b0, i[7]}, ctb_pkg::FMT_A, rn[17:0], {rn[27:16], rn[20] ? i[5:0] : rn[5:0]}, rn[30:13], i[5:0]);
    end
    $display("variant sweep done");
    @(posedge clock);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_b = 1'b1;
    chk(res, '0);
    chk(56'({busy, req, ci, vh}), 56'({2'h0, ctb_pkg::CMP_RST, ctb_pkg::VAR_RST}));
    ar = '0;
    br = '0;
    ev = ctb_pkg::VAR_RST;
    ec = ctb_pkg::CMP_RST;
    $display("mid-run reset done");
    for (int i = 0; i < 300; i++) begin
      rn = nx(rn);
      lgm = rn[9]; cmm = rn[8];
      run({1'b0, rn[0]}, lgm ? {2{rn[1]}} : rn[2:1], rn[31:14], rn[25:8], rn[22:5], rn[5:0]);
    end
    $display("random formats done");
    test_done();
  end
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
